// ===== core/dacc_pkg.sv
package dacc_pkg;
    localparam int unsigned DACC_INSTANCES = 3;
    localparam int unsigned DACC_DATA_W = 8;
    localparam int unsigned DACC_ADDR_W = 4;
    // register index per instance: instance n at base n*DACC_INST_STRIDE
    localparam logic [3:0] DACC_INST_STRIDE = 4'h2;
    localparam logic [3:0] DACC_OFF_CTRL = 4'h0;
    localparam logic [3:0] DACC_OFF_DATA = 4'h1;
    localparam int unsigned DACC_BIT_ENABLE = 0;
    localparam int unsigned DACC_BIT_OUTPUT_PIN_ENABLE = 6;
    localparam int unsigned DACC_BIT_RUNSTB = 7;
    localparam logic [7:0] DACC_CTRL_RESET = 8'h00;
    localparam logic [7:0] DACC_DATA_RESET = 8'h00;
    localparam logic [7:0] DACC_CTRL_MASK = 8'hc1;
    // start-up time after standby exit
    localparam int unsigned DACC_CLK_MHZ = 100;
    localparam int unsigned DACC_STARTUP_NS = 1000;
    localparam int unsigned DACC_STARTUP_CYC =
        (DACC_STARTUP_NS * DACC_CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        DACC_SLEEP_NONE,
        DACC_SLEEP_IDLE,
        DACC_SLEEP_STANDBY,
        DACC_SLEEP_POWERDOWN
    } dacc_sleep_t;

    typedef struct packed {
        logic [7:0] code;
        logic convert_start;
        logic core_enable;
        logic buffer_enable;
        logic pin_drive;
        logic internal_available;
    } dacc_analog_t;
endpackage : dacc_pkg

// ===== core/dacc_top.sv
// How it works
// - writing one to enable turns the converter on; writing zero turns it off.
// - when enabled, each data write starts a conversion two cycles later, once start-up is over.
// - when disabled, data write only stores; enable write later starts it.
// - pin drive only while output-pin enable is set.
// - output flagged available internally whenever enabled and not stopped by sleep, regardless of pin enable.
// - only instance zero has an external pin driver.
// - standby with run-in-standby set keeps the converter running.
// - standby without run-in-standby stops conversion, core and buffer off.
// - standby exit re-enables core and buffer, start-up delay before next conversion.
// - power-down always disables core and buffer.
// - data is 8 bits, linear from ground to reference.
// - debug halt does not stop or alter the converter.
// - three independent instances, each with control and data registers.
// - control bits: run-in-standby 7, pin enable 6, enable 0, reset zero.
// - data register at offset one, resets to zero.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
module dacc_top #(
    parameter int unsigned STARTUP_CYC = dacc_pkg::DACC_STARTUP_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [dacc_pkg::DACC_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire dacc_pkg::dacc_sleep_t sleep_mode,
    input wire logic debug_halt,
    output dacc_pkg::dacc_analog_t analog_out [dacc_pkg::DACC_INSTANCES]
);
    localparam int unsigned N = dacc_pkg::DACC_INSTANCES;
    localparam int unsigned CW = $clog2(STARTUP_CYC + 1);

    // the start-up counter needs at least one cycle to mean anything
    if (STARTUP_CYC < 1) begin : g_bad_startup
        $error("STARTUP_CYC must be at least one");
    end

    logic [7:0] ctrl_reg [N];
    logic [7:0] data_reg [N];
    logic [N-1:0] pending_reg;
    logic [CW-1:0] startup_reg [N];
    logic [N-1:0] sel_ctrl;
    logic [N-1:0] sel_data;
    logic [N-1:0] active;
    logic [N-1:0] stopped;
    logic unused_halt;

    // debug halt is deliberately ignored
    assign unused_halt = debug_halt;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_inst
            localparam logic [3:0] BASE = 4'(g) * dacc_pkg::DACC_INST_STRIDE;
            logic en;
            logic stby;
            assign sel_ctrl[g] = (addr == BASE + dacc_pkg::DACC_OFF_CTRL);
            assign sel_data[g] = (addr == BASE + dacc_pkg::DACC_OFF_DATA);
            assign en = ctrl_reg[g][dacc_pkg::DACC_BIT_ENABLE];
            assign stby = (sleep_mode == dacc_pkg::DACC_SLEEP_STANDBY);
            assign stopped[g] = (sleep_mode == dacc_pkg::DACC_SLEEP_POWERDOWN) ||
                (stby && !ctrl_reg[g][dacc_pkg::DACC_BIT_RUNSTB]);
            assign active[g] = en && !stopped[g];

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    ctrl_reg[g] <= dacc_pkg::DACC_CTRL_RESET;
                end else if (wr_en && sel_ctrl[g]) begin
                    ctrl_reg[g] <= wdata & dacc_pkg::DACC_CTRL_MASK;
                end
            end

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    data_reg[g] <= dacc_pkg::DACC_DATA_RESET;
                end else if (wr_en && sel_data[g]) begin
                    data_reg[g] <= wdata;
                end
            end

            // start-up counter: loaded while stopped, counts after wake
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    startup_reg[g] <= '0;
                end else if (stopped[g]) begin
                    startup_reg[g] <= CW'(STARTUP_CYC);
                end else if (startup_reg[g] != '0) begin
                    startup_reg[g] <= startup_reg[g] - CW'(1);
                end
            end

            // a request held back by sleep or start-up is issued once ready
            logic req;
            logic ready;
            assign ready = active[g] && (startup_reg[g] == '0);
            assign req = (wr_en && sel_data[g] && en) ||
                (wr_en && sel_ctrl[g] && wdata[dacc_pkg::DACC_BIT_ENABLE] && !en);

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    pending_reg[g] <= 1'b0;
                end else if (req) begin
                    pending_reg[g] <= 1'b1;
                end else if (ready || (wr_en && sel_ctrl[g] &&
                        !wdata[dacc_pkg::DACC_BIT_ENABLE])) begin
                    pending_reg[g] <= 1'b0;
                end
            end

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    analog_out[g] <= '0;
                end else begin
                    analog_out[g].code <= data_reg[g];
                    analog_out[g].convert_start <= pending_reg[g] && ready;
                    analog_out[g].core_enable <= active[g];
                    analog_out[g].buffer_enable <= active[g] &&
                        ctrl_reg[g][dacc_pkg::DACC_BIT_OUTPUT_PIN_ENABLE];
                    analog_out[g].pin_drive <= (g == 0) && active[g] &&
                        ctrl_reg[g][dacc_pkg::DACC_BIT_OUTPUT_PIN_ENABLE];
                    analog_out[g].internal_available <= active[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            rdata <= 8'h00;
            for (int i = 0; i < N; i++) begin
                if (sel_ctrl[i]) begin
                    rdata <= ctrl_reg[i];
                end
                if (sel_data[i]) begin
                    rdata <= data_reg[i];
                end
            end
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule : dacc_top

// ===== sim/dacc_props.sv
module dacc_props #(
    parameter int unsigned STARTUP_CYC = 2
) (
    input logic mclk,
    input logic resetn,
    input logic [3:0] addr,
    input logic [7:0] wdata,
    input logic wr_en,
    input logic rd_en,
    input logic [7:0] rdata,
    input dacc_pkg::dacc_sleep_t sleep_mode,
    input logic debug_halt,
    input dacc_pkg::dacc_analog_t analog_out [3]
);
    dacc_pkg::dacc_analog_t a0;
    logic [7:0] up_cnt;
    wire cw = wr_en && addr == 4'h0;
    wire dw = wr_en && addr == 4'h1;
    wire pd = sleep_mode == dacc_pkg::DACC_SLEEP_POWERDOWN;
    wire sb = sleep_mode == dacc_pkg::DACC_SLEEP_STANDBY;
    assign a0 = analog_out[0];
    // cycles since the last standby or power-down, so start-up waits are excluded
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) up_cnt <= 8'h00;
        else if (pd || sb) up_cnt <= 8'h00;
        else if (up_cnt != 8'hff) up_cnt <= up_cnt + 8'h01;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_pin_internal_only: assert property (!analog_out[1].pin_drive && !analog_out[2].pin_drive)
        else $error("pin drive on internal instance");
    a_enable_on: assert property (cw && wdata[0] && !pd && !sb |-> ##2 a0.core_enable && a0.internal_available)
        else $error("enable write not taken");
    a_enable_off: assert property (cw && !wdata[0] |-> ##2 !a0.core_enable && !a0.internal_available)
        else $error("disable write not taken");
    a_pin_off: assert property (cw && !wdata[6] |-> ##2 !a0.pin_drive)
        else $error("pin driven without pin enable");
    a_powerdown_off: assert property (pd |=> !a0.core_enable && !a0.buffer_enable)
        else $error("core on in power-down");
    a_start_core_on: assert property (a0.convert_start |-> a0.core_enable)
        else $error("start with core off");
    a_start_single: assert property (a0.convert_start && !$past(dw) |=> !a0.convert_start)
        else $error("start pulse too long");
    a_data_code: assert property (dw |-> ##2 a0.code == $past(wdata, 2))
        else $error("code does not follow data");
    a_enabled_start: assert property (dw && a0.core_enable && up_cnt > STARTUP_CYC + 2 |-> ##2 a0.convert_start)
        else $error("data write did not start");
    c_start: cover property (a0.convert_start);
    c_standby_run: cover property (sb && a0.core_enable);
    c_read: cover property (rd_en ##1 rdata != 8'h00);
endmodule : dacc_props
bind dacc_top dacc_props #(.STARTUP_CYC(STARTUP_CYC)) u_props (.*);

// ===== sim/dacc_top_tb.sv
module dacc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, resetn = 0, wr_en = 0, rd_en = 0, debug_halt = 0;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0, rdata;
    logic [7:0] m [6] = '{default: 8'h00};
    dacc_pkg::dacc_sleep_t sleep_mode = dacc_pkg::DACC_SLEEP_NONE;
    dacc_pkg::dacc_analog_t ao [3];
    int error_cnt = 0, comparisons = 0, n = 0;
    int unsigned seed = 67439;
    dacc_top #(.STARTUP_CYC(2)) DUT (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sleep_mode(sleep_mode),
        .debug_halt(debug_halt), .analog_out(ao));
    initial forever #5 mclk = ~mclk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task automatic step(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        debug_halt <= rnd() > 8'h7f;
        @(posedge mclk);
        wr_en <= 1'b0;
        if (a < 6) m[a] = a[0] ? d : d & 8'hc1;
        #1;
    endtask : wr
    task automatic rd(logic [3:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk("rdata", rdata, a < 6 ? m[a] : 8'h00);
    endtask : rd
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        for (int a = 0; a < 8; a++) rd(a[3:0]);
        for (int i = 0; i < 6; i++) wr(i[3:0], rnd() & 8'hfe);
        for (int i = 0; i < 6; i++) rd(i[3:0]);
        // reference assumed selected outside; data already written above
        wr(4'h0, 8'h41);
        step(1);
        chk("core", ao[0].core_enable, 1);
        chk("pin", ao[0].pin_drive, 1);
        chk("buffer", ao[0].buffer_enable, 1);
        chk("start", ao[0].convert_start, 1);
        chk("code", ao[0].code, m[1]);
        wr(4'h0, 8'h01);
        step(1);
        chk("pin", ao[0].pin_drive, 0);
        chk("avail", ao[0].internal_available, 1);
        wr(4'h1, rnd());
        step(1);
        chk("start", ao[0].convert_start, 1);
        wr(4'h3, rnd());
        step(1);
        chk("start1", ao[1].convert_start, 0);
        wr(4'h0, 8'h81);
        @(posedge mclk) sleep_mode <= dacc_pkg::DACC_SLEEP_STANDBY;
        step(2);
        chk("core", ao[0].core_enable, 1);
        wr(4'h0, 8'h01);
        step(1);
        chk("core", ao[0].core_enable, 0);
        wr(4'h0, 8'h81);
        @(posedge mclk) sleep_mode <= dacc_pkg::DACC_SLEEP_POWERDOWN;
        step(2);
        chk("core", ao[0].core_enable, 0);
        wr(4'h1, rnd());
        @(posedge mclk) sleep_mode <= dacc_pkg::DACC_SLEEP_NONE;
        n = 0;
        repeat (20) if (ao[0].convert_start !== 1'b1) begin
            step(1);
            n++;
        end
        chk("wake start", ao[0].convert_start, 1);
        chk("wake cycles", 8'(n), 8'h03);
        chk("core", ao[0].core_enable, 1);
        wr(4'h0, 8'h00);
        step(1);
        chk("avail", ao[0].internal_available, 0);
        summarize();
    end
    initial begin
        #100us;
        error_cnt++;
        summarize();
    end
endmodule : dacc_top_tb
